//--- inc/aomc_pkg.sv
// Shared constants and types for the converter output and mode control block
package aomc_pkg;
    // ==========================================================
    // Data path
    localparam int SAMPLE_W = 10;
    localparam int PIPE_LATENCY = 6;
    localparam logic [SAMPLE_W-1:0] CODE_ZERO = 10'h000;
    localparam logic [SAMPLE_W-1:0] CODE_FULL = 10'h3ff;
    localparam int MSB_POS = SAMPLE_W - 1;
    // ==========================================================
    // Format select level encoding (0, 1/3, 2/3, full supply)
    localparam logic [1:0] FMT_LVL_GND = 2'h0;
    localparam logic [1:0] FMT_LVL_THIRD = 2'h1;
    localparam logic [1:0] FMT_LVL_TWO_THIRD = 2'h2;
    localparam logic [1:0] FMT_LVL_FULL = 2'h3;
    // ==========================================================
    // Mode encoding
    typedef enum logic [1:0] {
        AOMC_NORMAL,
        AOMC_HIZ,
        AOMC_NAP,
        AOMC_SLEEP
    } aomc_mode_e;
    // ==========================================================
    // Interrupt status bit positions
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_MODE_BIT = 1;
    localparam int IRQ_W = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
    // ==========================================================
    // Register map, byte offsets
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK = 4'h4;
    localparam logic [3:0] REG_MODE = 4'h8;
    localparam logic [3:0] REG_LAST = 4'hc;
    localparam int REG_AW = 4;
endpackage : aomc_pkg

//--- rtl/aomc_pipe.sv
// Fixed-latency delay line carrying sample word, overflow flag and valid together
module aomc_pipe
    import aomc_pkg::*;
#(
    parameter int WIDTH = SAMPLE_W + 2,
    parameter int DEPTH = PIPE_LATENCY
) (
    input wire logic sys_clk, // System clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] din, // Stage entry
    output logic [WIDTH-1:0] dout // Stage exit after DEPTH edges
);
    logic [WIDTH-1:0] stage_q [DEPTH];

    // ==========================================================
    // Shift chain
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_q[i] <= '0;
            end
        end else begin
            stage_q[0] <= din;
            for (int i = 1; i < DEPTH; i++) begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    assign dout = stage_q[DEPTH-1];
endmodule : aomc_pipe

//--- rtl/aomc_sync.sv
// Two flip-flop synchroniser for a bundle of static pin levels
module aomc_sync #(
    parameter int WIDTH = 4
) (
    input wire logic sys_clk, // System clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] async_in, // Pin levels
    output logic [WIDTH-1:0] sync_out // Synchronised levels
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : aomc_sync

//--- rtl/aomc_top.sv
// Output format, power mode and overflow control of a 10-bit pipelined converter
// What this block does
// - Take one sample per clock rising edge
// - Output word appears seven cycles later
// - Normal mode: convert and drive outputs
// - Outputs high impedance, conversion continues
// - Nap mode, word and flag outputs high impedance
// - Sleep mode, word and flag outputs high impedance
// - Four-level select sets format and stabilizer
// - Flag high on over or under range
// - Ten-bit word, top bit is MSB
// - Binary codes run zero to all ones
module aomc_top
    import aomc_pkg::*;
(
    input wire logic sys_clk, // System clock, conversion clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic [SAMPLE_W-1:0] raw_code, // Quantised core result, binary
    input wire logic raw_over, // Core saw input above full scale
    input wire logic raw_under, // Core saw input below zero scale
    input wire logic power_down_select, // Pin, high selects nap or sleep
    input wire logic drive_enable_n, // Pin, low drives the outputs
    input wire logic [1:0] format_level, // Quantised four-level select pin
    input wire logic [REG_AW-1:0] reg_addr, // Register address
    input wire logic [31:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [31:0] reg_rdata, // Read data, one cycle after strobe
    output logic [SAMPLE_W-1:0] sample_word_out, // Parallel result word
    output logic [SAMPLE_W-1:0] sample_word_oe, // Drive enables for the word
    output logic range_overflow_flag, // Over or under range flag
    output logic range_overflow_oe, // Drive enable for the flag
    output logic data_msb_out, // Copy of the top data bit
    output logic stabilizer_on, // Clock duty cycle stabilizer enable
    output logic twos_comp_sel, // Two's complement format chosen
    output logic core_active, // Converter core powered
    output logic deep_sleep, // Deepest sleep chosen
    output logic irq // Level interrupt
);
    logic [3:0] pins_sync;
    logic pd_s;
    logic oen_s;
    logic [1:0] fmt_s;
    aomc_mode_e mode;
    aomc_mode_e mode_q;
    logic [SAMPLE_W+1:0] pipe_in;
    logic [SAMPLE_W+1:0] pipe_out;
    logic [SAMPLE_W-1:0] word_fmt;
    logic drive;
    logic [IRQ_W-1:0] status_q;
    logic [IRQ_W-1:0] mask_q;
    logic [IRQ_W-1:0] events;
    logic ovf_evt;
    logic [SAMPLE_W-1:0] last_word_q;
    logic last_ovf_q;
    logic twos_d;
    logic stab_d;
    logic pipe_valid;
    logic pipe_ovf;

    // ==========================================================
    // Helpers
    function automatic logic reg_hit(input logic strobe, input logic [REG_AW-1:0] addr,
        input logic [REG_AW-1:0] target);
        return strobe && (addr == target);
    endfunction : reg_hit

    // Two's complement is the binary code with the top bit inverted
    function automatic logic [SAMPLE_W-1:0] fmt_code(input logic [SAMPLE_W-1:0] code,
        input logic twos);
        return twos ? {~code[MSB_POS], code[MSB_POS-1:0]} : code;
    endfunction : fmt_code

    // Normal and high-impedance modes keep the core converting
    function automatic logic is_powered(input aomc_mode_e m);
        return (m == AOMC_NORMAL) || (m == AOMC_HIZ);
    endfunction : is_powered

    // ==========================================================
    // Static pin synchronisation
    aomc_sync #(
        .WIDTH(4)
    ) u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .async_in({format_level, ~drive_enable_n, power_down_select}),
        .sync_out(pins_sync)
    );
    assign pd_s = pins_sync[0];
    // The enable travels inverted so that a cleared synchroniser reads as
    // outputs off: nothing is driven after reset until the pin has been seen.
    assign oen_s = ~pins_sync[1];
    assign fmt_s = pins_sync[3:2];

    // ==========================================================
    // Mode decode
    always_comb begin
        unique case ({pd_s, oen_s})
            2'b00: mode = AOMC_NORMAL;
            2'b01: mode = AOMC_HIZ;
            2'b10: mode = AOMC_NAP;
            2'b11: mode = AOMC_SLEEP;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= AOMC_HIZ;
        end else begin
            mode_q <= mode;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            core_active <= 1'b0;
        end else begin
            core_active <= is_powered(mode);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            deep_sleep <= 1'b0;
        end else begin
            deep_sleep <= (mode == AOMC_SLEEP);
        end
    end

    // ==========================================================
    // Format and stabilizer select
    always_comb begin
        twos_d = 1'b0;
        stab_d = 1'b0;
        unique case (fmt_s)
            FMT_LVL_GND: begin
                twos_d = 1'b0;
                stab_d = 1'b0;
            end
            FMT_LVL_THIRD: begin
                twos_d = 1'b0;
                stab_d = 1'b1;
            end
            FMT_LVL_TWO_THIRD: begin
                twos_d = 1'b1;
                stab_d = 1'b1;
            end
            FMT_LVL_FULL: begin
                twos_d = 1'b1;
                stab_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            twos_comp_sel <= 1'b0;
        end else begin
            twos_comp_sel <= twos_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stabilizer_on <= 1'b0;
        end else begin
            stabilizer_on <= stab_d;
        end
    end

    // ==========================================================
    // Sample pipeline
    // Capture flop plus five delay stages; the output flop lands on the seventh edge.
    // Capture each edge
    assign pipe_in = {raw_over | raw_under, core_active, raw_code};

    aomc_pipe #(
        .WIDTH(SAMPLE_W + 2),
        .DEPTH(PIPE_LATENCY)
    ) u_pipe (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .din(pipe_in),
        .dout(pipe_out)
    );

    assign pipe_valid = pipe_out[SAMPLE_W];
    assign pipe_ovf = pipe_out[SAMPLE_W+1];

    assign word_fmt = fmt_code(pipe_out[SAMPLE_W-1:0], twos_comp_sel);

    assign drive = (mode_q == AOMC_NORMAL);

    // ==========================================================
    // Output drivers
    // Napping or sleeping cores produce no fresh data; the word freezes.
    // Top bit is MSB
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sample_word_out <= CODE_ZERO;
        end else if (pipe_valid) begin
            sample_word_out <= word_fmt;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_msb_out <= 1'b0;
        end else if (pipe_valid) begin
            data_msb_out <= word_fmt[MSB_POS];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            range_overflow_flag <= 1'b0;
        end else if (pipe_valid) begin
            range_overflow_flag <= pipe_ovf;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sample_word_oe <= CODE_ZERO;
        end else begin
            sample_word_oe <= drive ? CODE_FULL : CODE_ZERO;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            range_overflow_oe <= 1'b0;
        end else begin
            range_overflow_oe <= drive;
        end
    end

    // ==========================================================
    // Register file and interrupts
    assign ovf_evt = pipe_valid & pipe_ovf;
    assign events = {(mode != mode_q), ovf_evt};

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= IRQ_RESET;
        end else begin
            // Set wins over a simultaneous write-one clear
            if (reg_hit(reg_wr, reg_addr, REG_STATUS)) begin
                status_q <= (status_q & ~reg_wdata[IRQ_W-1:0]) | events;
            end else begin
                status_q <= status_q | events;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mask_q <= IRQ_RESET;
        end else if (reg_hit(reg_wr, reg_addr, REG_MASK)) begin
            mask_q <= reg_wdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            last_word_q <= CODE_ZERO;
            last_ovf_q <= 1'b0;
        end else if (pipe_valid) begin
            last_word_q <= word_fmt;
            last_ovf_q <= pipe_ovf;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((status_q | events) & mask_q);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_STATUS: reg_rdata <= {30'h000_0000, status_q};
                REG_MASK: reg_rdata <= {30'h000_0000, mask_q};
                REG_MODE: reg_rdata <= {26'h00_0000, deep_sleep, core_active,
                    stabilizer_on, twos_comp_sel, mode_q};
                REG_LAST: reg_rdata <= {21'h0_0000, last_ovf_q, last_word_q};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule : aomc_top

//--- tb/aomc_properties.sv
// Port assertions for the output and mode control block
module aomc_properties
    import aomc_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic rstn, // Reset
    input wire logic [SAMPLE_W-1:0] raw_code, // Code
    input wire logic raw_over, // Over
    input wire logic raw_under, // Under
    input wire logic power_down_select, // Pin
    input wire logic drive_enable_n, // Pin
    input wire logic [SAMPLE_W-1:0] sample_word_out, // Word
    input wire logic [SAMPLE_W-1:0] sample_word_oe, // Enables
    input wire logic range_overflow_flag, // Flag
    input wire logic range_overflow_oe, // Enable
    input wire logic twos_comp_sel, // Format
    input wire logic core_active, // Core on
    input wire logic deep_sleep // Sleep
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] act_q;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // ========
    // Steady conversion count, so pipeline checks skip wake-up
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) act_q <= 4'h0;
        else if (!core_active) act_q <= 4'h0;
        else if (act_q != 4'hf) act_q <= act_q + 4'h1;
    end
    AST_WORD_LATENCY: assert property (act_q == 4'hf && core_active |->
        sample_word_out[MSB_POS-1:0] == $past(raw_code[MSB_POS-1:0], 7))
        else $error("word latency");
    AST_FLAG_LATENCY: assert property (act_q == 4'hf && core_active |->
        range_overflow_flag == ($past(raw_over, 7) || $past(raw_under, 7))) else $error("flag");
    AST_MSB_FORMAT: assert property (act_q == 4'hf && core_active &&
        twos_comp_sel == $past(twos_comp_sel, 8) |->
        sample_word_out[MSB_POS] == ($past(raw_code[MSB_POS], 7) ^ twos_comp_sel))
        else $error("msb");
    AST_NORMAL_DRIVE: assert property ((!power_down_select && !drive_enable_n) [*8] |->
        core_active && range_overflow_oe && (&sample_word_oe)) else $error("normal");
    AST_HIZ_CONVERTS: assert property ((!power_down_select && drive_enable_n) [*8] |->
        core_active && !range_overflow_oe && sample_word_oe == '0) else $error("hiz");
    AST_OE_RELEASE: assert property ($rose(drive_enable_n) |->
        ##[1:5] !range_overflow_oe) else $error("release");
    AST_NAP_STATE: assert property ((power_down_select && !drive_enable_n) [*8] |->
        !core_active && !deep_sleep && !range_overflow_oe) else $error("nap");
    AST_SLEEP_STATE: assert property ((power_down_select && drive_enable_n) [*8] |->
        deep_sleep && !core_active && sample_word_oe == '0) else $error("sleep");
    cover property (act_q == 4'hf && range_overflow_flag);
    cover property (deep_sleep);
    cover property (twos_comp_sel && range_overflow_oe);
endmodule : aomc_properties
bind aomc_top aomc_properties u_props (.sys_clk, .rstn, .raw_code, .raw_over, .raw_under,
    .power_down_select, .drive_enable_n, .sample_word_out, .sample_word_oe,
    .range_overflow_flag, .range_overflow_oe, .twos_comp_sel, .core_active, .deep_sleep);

//--- tb/aomc_host_model.sv
// Capture logic model latching the converter word pins
module aomc_host_model
    import aomc_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic [SAMPLE_W-1:0] word, // Word pins
    input wire logic [SAMPLE_W-1:0] word_oe, // Enables
    input wire logic flag, // Flag pin
    input wire logic flag_oe, // Enable
    output logic [SAMPLE_W:0] cap_q, // Flag and word taken
    output int cap_count // Captures
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [SAMPLE_W:0] oe;
    logic [SAMPLE_W:0] pin;
    // Undriven pins drift: shown as the inverse of the last capture
    assign oe = {flag_oe, word_oe};
    assign pin = ({flag, word} & oe) | (~cap_q & ~oe);
    initial cap_q = '0;
    initial cap_count = 0;
    always @(posedge sys_clk) begin
        if (&oe) begin
            cap_q <= pin;
            cap_count <= cap_count + 1;
        end
    end
endmodule : aomc_host_model

//--- tb/tb_aomc_top.sv
// Self-checking bench for the output and mode control block
module tb_aomc_top
    import aomc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0, rstn = 1'b0, raw_over = 1'b0, raw_under = 1'b0;
    logic power_down_select = 1'b0, drive_enable_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [SAMPLE_W-1:0] raw_code = '0;
    logic [1:0] format_level = 2'h0;
    logic [REG_AW-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, rd_q;
    logic [SAMPLE_W-1:0] sample_word_out, sample_word_oe;
    logic range_overflow_flag, range_overflow_oe, data_msb_out, stabilizer_on;
    logic twos_comp_sel, core_active, deep_sleep, irq;
    logic [SAMPLE_W:0] cap_q;
    int cap_count, errors = 0, num_checks = 0;
    initial forever #5 sys_clk = ~sys_clk;
    aomc_top DUT (.sys_clk, .rstn, .raw_code, .raw_over, .raw_under, .power_down_select,
        .drive_enable_n, .format_level, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .sample_word_out, .sample_word_oe, .range_overflow_flag, .range_overflow_oe,
        .data_msb_out, .stabilizer_on, .twos_comp_sel, .core_active, .deep_sleep, .irq);
    aomc_host_model host (.sys_clk, .word(sample_word_out), .word_oe(sample_word_oe),
        .flag(range_overflow_flag), .flag_oe(range_overflow_oe), .cap_q, .cap_count);
    // ========
    // Shared tasks
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic wr(logic [REG_AW-1:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [REG_AW-1:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_q = reg_rdata;
    endtask : rd
    task automatic pulse_over();
        @(posedge sys_clk);
        raw_over <= 1'b1;
        @(posedge sys_clk);
        raw_over <= 1'b0;
        tick(10);
    endtask : pulse_over
    // Back-to-back samples, range ends and flags, in one format level
    task automatic t_stream(logic [1:0] lvl);
        logic [SAMPLE_W+1:0] tab [6] = '{12'h000, 12'h3ff, 12'h42a, 12'h955, 12'h200, 12'h1ff};
        logic [SAMPLE_W+1:0] e;
        @(posedge sys_clk);
        format_level <= lvl;
        tick(8);
        chk(twos_comp_sel, lvl[1]);
        chk(stabilizer_on, ^lvl);
        for (int j = 0; j < 14; j++) begin
            @(posedge sys_clk);
            {raw_under, raw_over, raw_code} <= tab[j > 5 ? 5 : j];
            #1;
            e = tab[j < 7 ? 0 : (j > 12 ? 5 : j - 7)];
            if (j > 6) chk(sample_word_out, {e[9] ^ lvl[1], e[8:0]});
            if (j > 6) chk(range_overflow_flag, |e[11:10]);
        end
        chk(data_msb_out, e[9] ^ lvl[1]);
        chk(cap_q, {|e[11:10], e[9] ^ lvl[1], e[8:0]});
    endtask : t_stream
    // Every pin pair: drive, conversion, power state, host captures
    task automatic t_modes();
        int c;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            {power_down_select, drive_enable_n} <= i[1:0];
            tick(12);
            @(posedge sys_clk);
            raw_code <= {8'h40, i[1:0]};
            tick(10);
            c = cap_count;
            rd(REG_LAST);
            chk(rd_q[9:0], i < 2 ? {8'hc0, i[1:0]} : 10'h301);
            chk(cap_count - c, i == 0 ? 2 : 0);
            chk(range_overflow_oe, i == 0);
            chk(sample_word_oe, i == 0 ? 10'h3ff : 10'h000);
            chk(core_active, i < 2);
            chk(deep_sleep, i == 3);
            rd(REG_MODE);
            chk(rd_q[1:0], i[1:0]);
        end
        @(posedge sys_clk);
        {power_down_select, drive_enable_n} <= 2'h0;
        tick(12);
    endtask : t_modes
    // Registers, sticky overflow status, mask and write-one clear
    task automatic t_irq();
        rd(REG_MASK);
        chk(rd_q, 32'h0000_0000);
        rd(4'h2);
        chk(rd_q, 32'h0000_0000);
        wr(REG_MODE, 32'h0000_0003);
        rd(REG_MODE);
        chk(rd_q[1:0], 2'h0);
        rd(REG_STATUS);
        chk(rd_q[IRQ_MODE_BIT], 1'b1);
        wr(REG_STATUS, 32'h0000_0003);
        rd(REG_STATUS);
        chk(rd_q, 32'h0000_0000);
        wr(REG_MASK, 32'h0000_0001);
        tick(3);
        chk(irq, 1'b0);
        pulse_over();
        chk(irq, 1'b1);
        rd(REG_STATUS);
        chk(rd_q[0], 1'b1);
        wr(REG_STATUS, 32'h0000_0001);
        tick(3);
        chk(irq, 1'b0);
        wr(REG_MASK, 32'h0000_0000);
        pulse_over();
        chk(irq, 1'b0);
    endtask : t_irq
    task automatic report_and_stop();
        if (errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        tick(6);
        for (int l = 0; l < 4; l++) t_stream(l[1:0]);
        t_modes();
        t_irq();
        report_and_stop();
    end
    // Whole run is under a thousand cycles
    initial begin
        #50000;
        errors++;
        report_and_stop();
    end
endmodule : tb_aomc_top
